// ### sipc_config_bank.v
// Sync, interrupt-pin, write-guard and host-mode configuration bank.
// Assumes the host port decoder delivers one-cycle write and read strobes
// with an address, and the phase core reports alignment and step status.
// Operation
// - A two-bit field places the frame-sync sample on target, half UI early, one UI or half UI late.
// - Writing one to the glide bit runs holdover, glide to zero, divider reset, glide back, then clears the bit.
// - A sync alarm rises when alignment error passes the selected plus-minus 1 to 8 UI limit.
// - A four-bit source field binds the frame-sync to input 1..14; codes 0 and 15 bind nothing.
// - With automatic enabling the sync counts only while its bound reference is selected.
// - Polarity bit clear signals interrupt low; set signals it high.
// - Key 0x85 opens all host writes, 0x86 opens exactly one, any other key blocks all but the key; boot-image writes ignore the key.
// - The test-reset pin defaults low so boundary scan stays off unless it is driven high.
// - Output scan cells never capture from the core, so the internal test is not offered.
`timescale 1ns/1ps
`default_nettype none
`include "sipc_regs.vh"
module sipc_config_bank
#(
  parameter ERR_W = 8
)
(
  input  wire             mclk,
  input  wire             reset_n,
  input  wire [6:0]       regAddr,
  input  wire [7:0]       regWrData,
  input  wire             regWrStb,
  input  wire             regRdStb,
  output reg  [7:0]       regRdData,
  input  wire [6:0]       bootAddr,
  input  wire [7:0]       bootData,
  input  wire             bootWrStb,
  input  wire             bootDone,
  output reg              hostReady,
  input  wire [2:0]       hostModePins,
  output reg  [2:0]       hostMode,
  input  wire             irqEvent,
  output reg              irqPinOut,
  output reg              irqPinOe,
  input  wire [ERR_W-1:0] syncErrUi,
  input  wire             syncErrValid,
  input  wire [3:0]       selectedRef,
  input  wire             autoSyncEnable,
  input  wire             frameSyncPin,
  output reg              syncAlarm,
  output reg              syncHonoured,
  output reg  [1:0]       syncSampleSel,
  output reg  [3:0]       syncSourceSel,
  input  wire             rampStepDone,
  output reg              phaseHoldover,
  output reg              rampToZero,
  output reg              dividerReset,
  output reg              rampToProg,
  input  wire             testResetPin,
  output reg              scanEnable,
  output reg              scanCoreCapture
);
  reg  [7:0] syncPhase_r;
  reg  [7:0] syncMon_r;
  reg  [7:0] irqCfg_r;
  reg  [7:0] guardKey_r;
  reg  [7:0] hostSel_r;
  reg        singleUsed_r;
  reg        modeCaught_r;
  reg        bootPending_r;
  wire       syncLevel;
  wire       testResetLevel;
  wire       rampFinished;
  wire       seqHold;
  wire       seqZero;
  wire       seqDiv;
  wire       seqProg;
  wire       seqFinish;
  wire [6:0] wrAddr;
  wire [7:0] wrData;
  wire       wrReq;
  wire       keyWrite;
  wire       guardOpen;
  wire       wrAllowed;
  wire       rampStart;
  wire [ERR_W-1:0] syncLimit;
  wire       sourceValid;
  wire       irqActive;

  // Frame-sync pin crosses into mclk
  sipc_sync3 uSyncPin
  (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .pinIn    (frameSyncPin),
    .levelOut (syncLevel)
  );

  // Test-reset pin crosses into mclk; reset value low keeps scan off
  sipc_sync3 uTrstPin
  (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .pinIn    (testResetPin),
    .levelOut (testResetLevel)
  );

  sipc_ramp_seq uRamp
  (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .start      (rampStart),
    .stepDone   (rampStepDone),
    .holdover   (seqHold),
    .rampToZero (seqZero),
    .divReset   (seqDiv),
    .rampToProg (seqProg),
    .finished   (seqFinish)
  );
  assign rampFinished = seqFinish;

  // boot image owns the write path until it is done
  assign wrAddr = bootPending_r ? bootAddr  : regAddr;
  assign wrData = bootPending_r ? bootData  : regWrData;
  assign wrReq  = bootPending_r ? bootWrStb : (regWrStb && hostReady);

  assign keyWrite  = wrReq && (wrAddr == `SIPC_OFF_GUARD_KEY);
  assign guardOpen = (guardKey_r == `SIPC_KEY_FULL) ||
                     ((guardKey_r == `SIPC_KEY_SINGLE) && !singleUsed_r);
  assign wrAllowed = wrReq && !keyWrite && (guardOpen || bootPending_r);
  assign rampStart = wrAllowed && (wrAddr == `SIPC_OFF_SYNC_MON) &&
                     wrData[`SIPC_BIT_RAMP] && !syncMon_r[`SIPC_BIT_RAMP];

  // Register writes; ramp bit self-clears when the sequence ends
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syncPhase_r  <= `SIPC_RST_SYNC_PHASE;
      syncMon_r    <= `SIPC_RST_SYNC_MON;
      irqCfg_r     <= `SIPC_RST_IRQ_CFG;
      guardKey_r   <= `SIPC_RST_GUARD_KEY;
      hostSel_r    <= `SIPC_RST_HOST_SEL;
      singleUsed_r <= 1'b0;
    end
    else
    begin
      // key always writable; a new key rearms single mode
      if (keyWrite)
      begin
        guardKey_r   <= wrData;
        singleUsed_r <= 1'b0;
      end
      else if (wrAllowed && (guardKey_r == `SIPC_KEY_SINGLE))
        singleUsed_r <= 1'b1;
      if (wrAllowed)
      begin
        case (wrAddr)
          `SIPC_OFF_SYNC_PHASE: syncPhase_r <= wrData;
          `SIPC_OFF_SYNC_MON:   syncMon_r   <= {syncMon_r[`SIPC_BIT_RAMP] |
                                               wrData[`SIPC_BIT_RAMP], wrData[6:0]};
          `SIPC_OFF_IRQ_CFG:    irqCfg_r    <= {5'h00, wrData[2:0]};
          `SIPC_OFF_HOST_SEL:   hostSel_r   <= {5'h00, wrData[2:0]};
          default:              syncPhase_r <= syncPhase_r;
        endcase
      end
      // bit returns to zero once calibration completes
      if (rampFinished)
        syncMon_r[`SIPC_BIT_RAMP] <= 1'b0;
      // mode pins caught once after reset release
      if (!modeCaught_r)
        hostSel_r <= {5'h00, hostModePins};
    end
  end

  // single capture flag and host gating for boot
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      modeCaught_r  <= 1'b0;
      bootPending_r <= 1'b0;
      hostReady     <= 1'b0;
      hostMode      <= 3'h0;
    end
    else
    begin
      modeCaught_r <= 1'b1;
      hostMode     <= hostSel_r[2:0];
      // host held off while the boot image loads
      if (!modeCaught_r)
        bootPending_r <= (hostModePins == `SIPC_MODE_EPROM);
      else if (bootDone)
        bootPending_r <= 1'b0;
      hostReady <= modeCaught_r && !bootPending_r && !(bootDone == 1'b0 &&
                   !modeCaught_r);
    end
  end

  // Read mux; unmapped addresses read as zero
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      regRdData <= 8'h00;
    else if (regRdStb)
    begin
      case (regAddr)
        `SIPC_OFF_SYNC_PHASE: regRdData <= syncPhase_r;
        `SIPC_OFF_SYNC_MON:   regRdData <= syncMon_r;
        `SIPC_OFF_IRQ_CFG:    regRdData <= irqCfg_r;
        `SIPC_OFF_GUARD_KEY:  regRdData <= guardKey_r;
        `SIPC_OFF_HOST_SEL:   regRdData <= hostSel_r;
        default:              regRdData <= 8'h00;
      endcase
    end
  end

  // limit code n selects plus-minus n+1 UI
  assign syncLimit   = {{(ERR_W-3){1'b0}}, syncMon_r[6:4]} + {{(ERR_W-1){1'b0}}, 1'b1};
  // only codes 1..14 name an input
  assign sourceValid = (syncMon_r[3:0] >= `SIPC_SRC_FIRST) &&
                       (syncMon_r[3:0] <= `SIPC_SRC_LAST);
  assign irqActive   = irqEvent;

  // Sync monitor, sample placement and reference binding
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syncAlarm       <= 1'b0;
      syncHonoured    <= 1'b0;
      syncSampleSel   <= 2'h0;
      syncSourceSel   <= 4'h0;
    end
    else
    begin
      // sample placement passed to the sampler
      syncSampleSel <= syncPhase_r[1:0];
      syncSourceSel <= sourceValid ? syncMon_r[3:0] : 4'h0;
      // auto mode honours sync only for the selected reference
      syncHonoured  <= syncLevel && sourceValid &&
                       (!autoSyncEnable || (selectedRef == syncMon_r[3:0]));
      // alarm on misalignment beyond the limit
      if (syncErrValid)
        syncAlarm <= (syncErrUi > syncLimit);
    end
  end

  // glide steps retimed so every output leaves a flop of this module
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phaseHoldover <= 1'b0;
      rampToZero    <= 1'b0;
      dividerReset  <= 1'b0;
      rampToProg    <= 1'b0;
    end
    else
    begin
      phaseHoldover <= seqHold;
      rampToZero    <= seqZero;
      dividerReset  <= seqDiv;
      rampToProg    <= seqProg;
    end
  end

  // Interrupt pin; enable held low when released so a wired line
  // can be shared with other sources
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqPinOut <= 1'b0;
      irqPinOe  <= 1'b0;
    end
    else
    begin
      // pin reused as plain output at polarity level
      if (irqCfg_r[`SIPC_BIT_PIN_GPO])
      begin
        irqPinOut <= irqCfg_r[`SIPC_BIT_POLARITY];
        irqPinOe  <= 1'b1;
      end
      else
      begin
        irqPinOut <= irqActive ? irqCfg_r[`SIPC_BIT_POLARITY]
                               : ~irqCfg_r[`SIPC_BIT_POLARITY];
        // release mode drives only while active
        irqPinOe  <= !irqCfg_r[`SIPC_BIT_RELEASE] || irqActive;
      end
    end
  end

  // Scan controls; pin flops reset low, matching the internal pull-down
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scanEnable      <= 1'b0;
      scanCoreCapture <= 1'b0;
    end
    else
    begin
      scanEnable      <= testResetLevel;
      scanCoreCapture <= 1'b0;
    end
  end
endmodule // sipc_config_bank
`default_nettype wire

// ### sipc_host_model.sv
// Host processor model on the register port: byte writes and reads.
// Assumes the bank takes one-cycle strobes and answers reads a cycle later.
`timescale 1ns/1ps
`default_nettype none
module sipc_host_model
(
  input  wire logic       mclk,
  output var  logic [6:0] regAddr,
  output var  logic [7:0] regWrData,
  output var  logic       regWrStb,
  output var  logic       regRdStb,
  input  wire logic [7:0] regRdData
);
  // Idle bus at start
  initial
  begin
    regAddr = 7'h00;
    regWrData = 8'h00;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
  end

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    regAddr = a;
    regWrData = d;
    regWrStb = 1'b1;
    @(posedge mclk);
    #1;
    regWrStb = 1'b0;
    regAddr = ~a;    // Released bus shows no stale value
    regWrData = ~d;
  endtask

  // Read data taken after the strobe edge
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    regAddr = a;
    regRdStb = 1'b1;
    @(posedge mclk);
    #1;
    regRdStb = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask
endmodule // sipc_host_model
`default_nettype wire

// ### sipc_monitor.sv
// Checker for the sync, glide, interrupt-pin and scan outputs of the bank.
// Assumes it is bound to sipc_config_bank and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sipc_monitor
#(
  parameter ERR_W = 8
)
(
  input wire logic             mclk,
  input wire logic             reset_n,
  input wire logic             irqEvent,
  input wire logic             irqPinOe,
  input wire logic             testResetPin,
  input wire logic             scanEnable,
  input wire logic             scanCoreCapture,
  input wire logic [3:0]       syncSourceSel,
  input wire logic             syncHonoured,
  input wire logic             autoSyncEnable,
  input wire logic [3:0]       selectedRef,
  input wire logic             phaseHoldover,
  input wire logic             rampToZero,
  input wire logic             dividerReset,
  input wire logic             rampToProg,
  input wire logic [ERR_W-1:0] syncErrUi,
  input wire logic             syncErrValid,
  input wire logic             syncAlarm
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  a_scan_no_capture: assert property (!scanCoreCapture)
    else $error("scan cells capture from core");
  a_scan_off_low: assert property (!testResetPin [*6] |-> !scanEnable)
    else $error("scan enabled with test reset low");
  a_oe_when_active: assert property (irqEvent [*3] |-> irqPinOe)
    else $error("interrupt pin not driven while active");
  a_source_code_ok: assert property (syncSourceSel != 4'hF)
    else $error("unused source code selected");
  a_honour_bound_ref: assert property (syncHonoured && autoSyncEnable && $past(autoSyncEnable)
    && $stable(selectedRef) && $stable(syncSourceSel) |-> selectedRef == syncSourceSel)
    else $error("sync honoured on another reference");
  a_glide_in_hold: assert property ((rampToZero || dividerReset || rampToProg)
    |-> phaseHoldover)
    else $error("glide step outside holdover");
  a_div_one_cycle: assert property (dividerReset
    |-> !rampToZero && !rampToProg ##1 !dividerReset)
    else $error("divider reset overlaps or lingers");
  a_alarm_far_err: assert property (syncErrValid && syncErrUi > 8 |=> syncAlarm)
    else $error("no alarm beyond widest limit");
  a_alarm_zero_err: assert property (syncErrValid && syncErrUi == 0 |=> !syncAlarm)
    else $error("alarm on aligned sync");
endmodule // sipc_monitor

bind sipc_config_bank sipc_monitor #(.ERR_W(ERR_W)) i_mon
(
  .mclk, .reset_n, .irqEvent, .irqPinOe, .testResetPin, .scanEnable, .scanCoreCapture,
  .syncSourceSel, .syncHonoured, .autoSyncEnable, .selectedRef, .phaseHoldover,
  .rampToZero, .dividerReset, .rampToProg, .syncErrUi, .syncErrValid, .syncAlarm
);
`default_nettype wire

// ### sipc_ramp_seq.v
// Sequencer for the phase-offset glide calibration.
// Assumes the phase core answers each step with a one-cycle done pulse.
`timescale 1ns/1ps
`default_nettype none
module sipc_ramp_seq
(
  input  wire mclk,
  input  wire reset_n,
  input  wire start,
  input  wire stepDone,
  output reg  holdover,
  output reg  rampToZero,
  output reg  divReset,
  output reg  rampToProg,
  output reg  finished
);
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_HOLD = 6'h02;
  localparam [5:0] ST_ZERO = 6'h04;
  localparam [5:0] ST_DIV  = 6'h08;
  localparam [5:0] ST_PROG = 6'h10;
  localparam [5:0] ST_EXIT = 6'h20;

  reg [5:0] state_r;
  reg [5:0] state_nxt;

  // Step order: hold, glide to zero, divider reset, glide back, release
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (start) state_nxt = ST_HOLD;
      ST_HOLD: state_nxt = ST_ZERO;
      ST_ZERO: if (stepDone) state_nxt = ST_DIV;
      ST_DIV:  state_nxt = ST_PROG;
      ST_PROG: if (stepDone) state_nxt = ST_EXIT;
      ST_EXIT: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Registered step outputs
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r    <= ST_IDLE;
      holdover   <= 1'b0;
      rampToZero <= 1'b0;
      divReset   <= 1'b0;
      rampToProg <= 1'b0;
      finished   <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      holdover   <= (state_nxt != ST_IDLE) && (state_nxt != ST_EXIT);
      rampToZero <= (state_nxt == ST_ZERO);
      divReset   <= (state_nxt == ST_DIV);
      rampToProg <= (state_nxt == ST_PROG);
      finished   <= (state_nxt == ST_EXIT);
    end
  end
endmodule // sipc_ramp_seq
`default_nettype wire

// ### sipc_regs.vh
// Register map, field positions and reset values for the sync, interrupt
// and write-guard configuration bank.
// Assumes inclusion by the bank and its helper modules only.
`ifndef SIPC_REGS_VH
`define SIPC_REGS_VH
`define SIPC_ADDR_W           7
`define SIPC_OFF_SYNC_PHASE   7'h7B
`define SIPC_OFF_SYNC_MON     7'h7C
`define SIPC_OFF_IRQ_CFG      7'h7D
`define SIPC_OFF_GUARD_KEY    7'h7E
`define SIPC_OFF_HOST_SEL     7'h7F
`define SIPC_RST_SYNC_PHASE   8'h00
`define SIPC_RST_SYNC_MON     8'h00
`define SIPC_RST_IRQ_CFG      8'h02
`define SIPC_RST_GUARD_KEY    8'h85
`define SIPC_RST_HOST_SEL     8'h00
`define SIPC_KEY_FULL         8'h85
`define SIPC_KEY_SINGLE       8'h86
`define SIPC_BIT_RAMP         7
`define SIPC_BIT_PIN_GPO      2
`define SIPC_BIT_RELEASE      1
`define SIPC_BIT_POLARITY     0
`define SIPC_MODE_EPROM       3'h1
`define SIPC_MODE_MUX         3'h2
`define SIPC_MODE_INTEL       3'h3
`define SIPC_MODE_MOTO        3'h4
`define SIPC_MODE_SERIAL      3'h5
`define SIPC_SRC_FIRST        4'h1
`define SIPC_SRC_LAST         4'hE
`endif

// ### sipc_sync3.v
// Three-stage synchroniser for one pin level.
// Assumes a single clock; the first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module sipc_sync3
(
  input  wire mclk,
  input  wire reset_n,
  input  wire pinIn,
  output reg  levelOut
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // Change accepted only when stages two and three agree
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_r     <= 1'b0;
      s2_r     <= 1'b0;
      s3_r     <= 1'b0;
      levelOut <= 1'b0;
    end
    else
    begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        levelOut <= s3_r;
    end
  end
endmodule // sipc_sync3
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the sync, interrupt and guard configuration bank.
// Assumes the host model drives the register port; bench plays the core.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       mclk, reset_n, bootWrStb, bootDone, irqEvent, syncErrValid, autoSyncEnable;
  logic       frameSyncPin, rampStepDone, testResetPin, hostReady, irqPinOut, irqPinOe;
  logic       syncAlarm, syncHonoured, phaseHoldover, rampToZero, dividerReset, rampToProg;
  logic       scanEnable, scanCoreCapture;
  logic [6:0] bootAddr;
  logic [7:0] bootData, regRdData, syncErrUi;
  logic [2:0] hostModePins, hostMode;
  logic [3:0] selectedRef, syncSourceSel;
  logic [1:0] syncSampleSel;
  wire  [6:0] regAddr;
  wire  [7:0] regWrData;
  wire        regWrStb, regRdStb;
  int         error_cnt = 0;
  int         comparisons = 0;

  sipc_config_bank #(.ERR_W(8)) i_dut
  (
    .mclk, .reset_n, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .bootAddr,
    .bootData, .bootWrStb, .bootDone, .hostReady, .hostModePins, .hostMode, .irqEvent,
    .irqPinOut, .irqPinOe, .syncErrUi, .syncErrValid, .selectedRef, .autoSyncEnable,
    .frameSyncPin, .syncAlarm, .syncHonoured, .syncSampleSel, .syncSourceSel,
    .rampStepDone, .phaseHoldover, .rampToZero, .dividerReset, .rampToProg,
    .testResetPin, .scanEnable, .scanCoreCapture
  );
  sipc_host_model i_host
  (
    .mclk, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData
  );

  // Free-running 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] g;
    i_host.rd(a, g);
    chk($sformatf("reg%h", a), e, g);
  endtask

  // Bounded wait; a missed step shows as a mismatch
  task automatic wt(ref logic s, input string n);
    int k;
    k = 0;
    while (s !== 1'b1 && k < 60)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    chk(n, 8'h01, {7'h00, s});
  endtask

  task automatic pulse(ref logic s);
    @(posedge mclk);
    #1;
    s = 1'b1;
    @(posedge mclk);
    #1;
    s = 1'b0;
  endtask

  function automatic logic [1:0] pinExp(input logic [2:0] c, input logic a);
    if (c[2])
      return {1'b1, c[0]};
    return {!c[1] || a, a ? c[0] : !c[0]};
  endfunction

  task automatic syncCase(input logic [3:0] r, input logic au, input logic p, input logic e);
    selectedRef = r;
    autoSyncEnable = au;
    frameSyncPin = p;
    repeat (8) @(posedge mclk);
    #1;
    chk("honoured", {7'h00, e}, {7'h00, syncHonoured});
  endtask

  task automatic finish_test;
    if (error_cnt == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    logic [7:0] v;
    int i;
    void'($urandom(32'h41a048b9));
    {reset_n, bootWrStb, bootDone, irqEvent, syncErrValid, autoSyncEnable} = 6'h00;
    {frameSyncPin, rampStepDone, testResetPin, bootAddr, bootData, syncErrUi} = 26'h0;
    selectedRef = 4'h0;
    hostModePins = 3'h1;
    repeat (5) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk("ready", 8'h00, {7'h00, hostReady});
    {bootAddr, bootData, bootWrStb} = {7'h7D, 8'h05, 1'b1};
    @(posedge mclk);
    #1;
    {bootWrStb, bootDone} = 2'b01;
    wt(hostReady, "ready");
    bootDone = 1'b0;
    hostModePins = 3'h4;
    rdc(7'h7D, 8'h05);
    rdc(7'h7F, 8'h01);
    rdc(7'h7B, 8'h00);
    rdc(7'h7E, 8'h85);
    rdc(7'h20, 8'h00);
    v = $urandom;
    i_host.wr(7'h7B, v);
    rdc(7'h7B, v);
    i_host.wr(7'h7E, 8'h11);
    i_host.wr(7'h7B, ~v);
    rdc(7'h7B, v);
    i_host.wr(7'h7E, 8'h86);
    i_host.wr(7'h7B, ~v);
    i_host.wr(7'h7B, v);
    rdc(7'h7B, ~v);
    i_host.wr(7'h7E, 8'h85);
    for (i = 0; i < 4; i++)
    begin
      v = {$urandom, i[1:0]};
      i_host.wr(7'h7B, v);
      rdc(7'h7B, v);
      chk("sample", {6'h00, i[1:0]}, {6'h00, syncSampleSel});
    end
    for (i = 0; i < 16; i++)
    begin
      i_host.wr(7'h7C, {1'b0, 3'($urandom), i[3:0]});
      repeat (2) @(posedge mclk);
      #1;
      chk("source", (i == 0 || i == 15) ? 8'h00 : i[7:0], {4'h0, syncSourceSel});
    end
    for (i = 0; i < 8; i++)
    begin
      i_host.wr(7'h7C, {1'b0, i[2:0], 4'h5});
      syncErrUi = i[7:0] + 8'h01;
      pulse(syncErrValid);
      chk("alarm", 8'h00, {7'h00, syncAlarm});
      syncErrUi = i[7:0] + 8'h02;
      pulse(syncErrValid);
      chk("alarm", 8'h01, {7'h00, syncAlarm});
    end
    // Aligned sync clears the alarm
    syncErrUi = 8'h00;
    pulse(syncErrValid);
    chk("alarm", 8'h00, {7'h00, syncAlarm});
    syncCase(4'h5, 1'b1, 1'b1, 1'b1);
    syncCase(4'h6, 1'b1, 1'b1, 1'b0);
    syncCase(4'h6, 1'b0, 1'b1, 1'b1);
    syncCase(4'h5, 1'b1, 1'b0, 1'b0);
    for (i = 0; i < 16; i++)
    begin
      i_host.wr(7'h7D, {5'h00, i[2:0]});
      irqEvent = i[3];
      repeat (3) @(posedge mclk);
      #1;
      chk("irqpin", {6'h00, pinExp(i[2:0], i[3])}, {6'h00, irqPinOe, irqPinOut});
    end
    i_host.wr(7'h7C, 8'h85);
    wt(phaseHoldover, "hold");
    wt(rampToZero, "zero");
    pulse(rampStepDone);
    wt(dividerReset, "divrst");
    wt(rampToProg, "prog");
    pulse(rampStepDone);
    repeat (6) @(posedge mclk);
    #1;
    chk("hold", 8'h00, {7'h00, phaseHoldover});
    rdc(7'h7C, 8'h05);
    testResetPin = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    chk("scan", 8'h01, {6'h00, scanCoreCapture, scanEnable});
    testResetPin = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    chk("scan", 8'h00, {7'h00, scanEnable});
    chk("mode", 8'h01, {5'h00, hostMode});
    // straps caught again at a second reset, ignored afterwards
    hostModePins = 3'h4;
    irqEvent = 1'b0;
    reset_n = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    wt(hostReady, "ready");
    hostModePins = 3'h2;
    rdc(7'h7F, 8'h04);
    rdc(7'h7D, 8'h02);
    chk("irqpin", {6'h00, pinExp(3'h2, 1'b0)}, {6'h00, irqPinOe, irqPinOut});
    chk("mode", 8'h04, {5'h00, hostMode});
    finish_test;
  end

  // Watchdog well past the few hundred cycles the tests need
  initial
  begin
    #200000;
    error_cnt++;
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
